/* File: verilog/tws_pkg.sv */
// Package with register map, field positions and timing for the two-wire master block
package tws_pkg;
  // Register byte offsets (AHB-Lite, one word each)
  localparam logic [7:0] TWS_OFF_CONTROL = 8'h00;
  localparam logic [7:0] TWS_OFF_STATUS = 8'h04;
  localparam logic [7:0] TWS_OFF_TX_HOLD = 8'h08;
  localparam logic [7:0] TWS_OFF_RX_HOLD = 8'h0C;
  localparam logic [7:0] TWS_OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] TWS_OFF_IRQ_MASK = 8'h14;
  localparam logic [7:0] TWS_OFF_ENABLE = 8'h18;
  // Control register field positions
  localparam int TWS_CTL_START = 0;
  localparam int TWS_CTL_RESTART = 1;
  localparam int TWS_CTL_STOP = 2;
  localparam int TWS_CTL_RECV = 3;
  localparam int TWS_CTL_ACK = 4;
  localparam int TWS_CTL_ACKVAL = 5;
  // Status register field positions
  localparam int TWS_ST_TXFULL = 0;
  localparam int TWS_ST_RXFULL = 1;
  localparam int TWS_ST_DIR = 2;
  localparam int TWS_ST_START = 3;
  // Interrupt event bit positions
  localparam int TWS_IRQ_SEQ_DONE = 0;
  localparam int TWS_IRQ_RX_DONE = 1;
  localparam int TWS_IRQ_TX_DONE = 2;
  localparam int TWS_IRQ_STOP_SEEN = 3;
  localparam int TWS_IRQ_W = 4;
  // Timing: one quarter of a bus bit period
  localparam int TWS_CLK_MHZ = 100;
  localparam int TWS_QUARTER_NS = 1250;
  localparam int TWS_QUARTER_CYC = (TWS_QUARTER_NS * TWS_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] TWS_QUARTER_MAX = 8'(TWS_QUARTER_CYC - 1);
  // Generic widths, bus codes and counter limits
  localparam int TWS_REQ_W = 5;
  localparam logic [1:0] TWS_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] TWS_HSIZE_WORD = 3'h2;
  localparam logic [3:0] TWS_BITS_MAX = 4'h8;
  localparam logic [2:0] TWS_PH_LAST = 3'h3;
  // Master sequencer states
  typedef enum logic [2:0] {
    TWS_IDLE = 3'b000,
    TWS_START = 3'b001,
    TWS_RESTART = 3'b010,
    TWS_STOP = 3'b011,
    TWS_XMIT = 3'b100,
    TWS_RECV = 3'b101,
    TWS_ACK = 3'b110
  } tws_state_e;
endpackage

/* File: verilog/tws_bus_watch.sv */
// Bus condition watcher: synchronises the lines and flags start, stop and rising clock edges
`timescale 1ns/1ps
`default_nettype none
module tws_bus_watch (
  input wire logic clk_in, // System clock
  input wire logic rstn_in, // Async reset, active low
  input wire logic scl_pin_in, // Raw clock line
  input wire logic sda_pin_in, // Raw data line
  output logic scl_out, // Synchronised clock level
  output logic sda_out, // Synchronised data level
  output logic scl_rise_out, // Clock rising edge pulse
  output logic start_seen_out, // Start or repeated start pulse
  output logic stop_seen_out // Stop pulse
);
  import tws_pkg::*;
  // Two-stage synchronisers plus one history stage
  typedef struct packed {
    logic [1:0] scl_meta;
    logic [1:0] sda_meta;
    logic scl_old;
    logic sda_old;
  } tws_watch_s;
  tws_watch_s st_q, st_d;
  // Next-state: shift the synchronisers
  always_comb begin
    st_d = st_q;
    st_d.scl_meta = {st_q.scl_meta[0], scl_pin_in};
    st_d.sda_meta = {st_q.sda_meta[0], sda_pin_in};
    st_d.scl_old = st_q.scl_meta[1];
    st_d.sda_old = st_q.sda_meta[1];
  end
  // Registers idle high, as the bus does
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q <= '1;
    end else begin
      st_q <= st_d;
    end
  end
  // Only the second stage and the history stage are looked at
  assign scl_out = st_q.scl_meta[1];
  assign sda_out = st_q.sda_meta[1];
  assign scl_rise_out = st_q.scl_meta[1] & ~st_q.scl_old;
  // Data falls while clock high
  assign start_seen_out = st_q.scl_meta[1] & st_q.scl_old & st_q.sda_old & ~st_q.sda_meta[1];
  // Data rises while clock high
  assign stop_seen_out = st_q.scl_meta[1] & st_q.scl_old & ~st_q.sda_old & st_q.sda_meta[1];
endmodule
`default_nettype wire

/* File: verilog/tws_master.sv */
// Two-wire master sequencer with control/status registers on AHB-Lite
// Notes on behaviour
// - Ack value picks ACK or NACK driven
// - Ack request drives ack slot, self-clears
// - Receive request takes one byte, self-clears
// - Stop request makes stop, self-clears after
// - Restart request makes repeated start, self-clears
// - Start request makes start, self-clears after
// - Start-seen set on start, cleared on stop
// - Direction bit updated after slave address byte
// - Rx full set on load, cleared on read
// - Tx full set on write, cleared when sent
`timescale 1ns/1ps
`default_nettype none
module tws_master (
  input wire logic clk_in, // System clock, 100 MHz
  input wire logic rstn_in, // Async reset, active low
  input wire logic hsel_in, // AHB slave select
  input wire logic [31:0] haddr_in, // AHB address
  input wire logic [1:0] htrans_in, // AHB transfer type
  input wire logic hwrite_in, // AHB write flag
  input wire logic [2:0] hsize_in, // AHB size
  input wire logic [31:0] hwdata_in, // AHB write data
  input wire logic hready_in, // AHB bus ready
  output logic [31:0] hrdata_out, // AHB read data
  output logic hreadyout_out, // AHB slave ready
  output logic hresp_out, // AHB response, always OKAY
  input wire logic scl_in, // Clock line level
  output logic scl_out, // Clock line drive value (low)
  output logic scl_oe_out, // Clock line pull-low enable
  input wire logic sda_in, // Data line level
  output logic sda_out, // Data line drive value (low)
  output logic sda_oe_out, // Data line pull-low enable
  output logic irq_out // Level interrupt
);
  import tws_pkg::*;

  // Whole block state
  typedef struct packed {
    // Bus slave bookkeeping
    logic a_wr; // Pending write in data phase
    logic a_rd; // Pending read in data phase
    logic [7:0] a_off; // Latched offset
    // Software-visible control and status
    logic [TWS_REQ_W-1:0] req; // Start, restart, stop, recv, ack requests
    logic ack_value; // Ack value bit
    logic enable; // Slave watching on
    logic start_flag; // Last condition was a start
    logic dir_flag; // Slave transfer direction
    logic rx_full; // Receive holding full
    logic tx_full; // Transmit holding full
    logic [7:0] tx_hold; // Transmit holding reg
    logic [7:0] rx_hold; // Receive holding reg
    logic [TWS_IRQ_W-1:0] irq_stat; // Sticky events
    logic [TWS_IRQ_W-1:0] irq_mask; // Event enables
    // Line sequencer
    tws_state_e state; // Master sequencer
    logic [1:0] phase; // Quarter within a bit
    logic [7:0] tick; // Quarter-period counter
    logic [3:0] bitn; // Bit counter
    logic [7:0] shreg; // Shift register
    logic scl_low; // Pull clock low
    logic sda_low; // Pull data low
    // Address watch for the direction bit
    logic [3:0] sl_bits; // Slave address bit counter
    logic [7:0] sl_shift; // Slave address shifter
  } tws_s;
  tws_s r_q, r_d;

  // Watcher outputs, two flip-flops behind the pins
  logic bus_scl, bus_sda, bus_rise, bus_start, bus_stop;

  // Line watcher with synchronisers
  // Conditions are judged on synchronised levels only
  tws_bus_watch u_watch (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .scl_pin_in(scl_in),
    .sda_pin_in(sda_in),
    .scl_out(bus_scl),
    .sda_out(bus_sda),
    .scl_rise_out(bus_rise),
    .start_seen_out(bus_start),
    .stop_seen_out(bus_stop)
  );

  // Decode the request bits to one state, lowest bit first
  // One write may set several bits; the rest wait their turn
  // A held byte with no request pending becomes a transmit
  function automatic tws_state_e pick_seq(input logic [TWS_REQ_W-1:0] rq, input logic txf);
    tws_state_e s;
    // Fixed priority keeps the order predictable
    s = TWS_IDLE;
    if (rq[TWS_CTL_START]) s = TWS_START;
    else if (rq[TWS_CTL_RESTART]) s = TWS_RESTART;
    else if (rq[TWS_CTL_STOP]) s = TWS_STOP;
    else if (rq[TWS_CTL_RECV]) s = TWS_RECV;
    else if (rq[TWS_CTL_ACK]) s = TWS_ACK;
    else if (txf) s = TWS_XMIT;
    return s;
  endfunction

  // Read mux for the register offsets
  // Uses the offset latched in the address phase
  function automatic logic [31:0] read_reg(input tws_s r);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (r.a_off)
      // Request bits read one until hardware clears them
      TWS_OFF_CONTROL: begin
        v[TWS_REQ_W-1:0] = r.req;
        v[TWS_CTL_ACKVAL] = r.ack_value;
      end
      // Status bits are read only
      TWS_OFF_STATUS: begin
        v[TWS_ST_TXFULL] = r.tx_full;
        v[TWS_ST_RXFULL] = r.rx_full;
        v[TWS_ST_DIR] = r.dir_flag;
        v[TWS_ST_START] = r.start_flag;
      end
      TWS_OFF_TX_HOLD: v[7:0] = r.tx_hold;
      TWS_OFF_RX_HOLD: v[7:0] = r.rx_hold;
      TWS_OFF_IRQ_STAT: v[TWS_IRQ_W-1:0] = r.irq_stat;
      TWS_OFF_IRQ_MASK: v[TWS_IRQ_W-1:0] = r.irq_mask;
      TWS_OFF_ENABLE: v[0] = r.enable;
      // Unmapped offsets read zero
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // Next-state logic for the bus slave, registers and sequencer
  // Hardware sets are applied after software clears, so they win
  always_comb begin
    logic take;
    logic qtick;
    logic seq_end;
    logic [TWS_IRQ_W-1:0] ev;
    take = 1'b0;
    qtick = 1'b0;
    seq_end = 1'b0;
    ev = '0;
    // Every field holds unless a branch below moves it
    r_d = r_q;

    // Address phase capture, only whole-word transfers are meaningful
    // hsize is not decoded: every access counts as a whole word
    take = hsel_in && hready_in && (htrans_in == TWS_HTRANS_NONSEQ);
    r_d.a_wr = take && hwrite_in;
    r_d.a_rd = take && !hwrite_in;
    if (take) begin
      r_d.a_off = haddr_in[7:0];
    end

    // Quarter-bit timer runs only during a sequence
    // Held at zero in idle so each sequence starts on a fresh quarter
    if (r_q.state == TWS_IDLE || r_q.tick == TWS_QUARTER_MAX) begin
      r_d.tick = 8'h00;
      qtick = (r_q.state != TWS_IDLE);
    end else begin
      r_d.tick = r_q.tick + 8'h01;
    end

    // Clock stretching: hold the quarter while a released clock is still low
    // A slow partner may hold the clock low; the quarter waits for it
    if (qtick && !r_q.scl_low && !bus_scl) begin
      qtick = 1'b0;
      r_d.tick = r_q.tick;
    end

    // Sequencer
    // Only one state runs at a time, so requests never overlap
    unique case (r_q.state)
      // Idle: pick the next job and preload the shifter
      TWS_IDLE: begin
        r_d.state = pick_seq(r_q.req, r_q.tx_full);
        r_d.phase = 2'h0;
        r_d.bitn = 4'h0;
        r_d.shreg = r_q.tx_hold;
      end
      // Start: data falls with clock high, then clock falls
      TWS_START: begin
        if (qtick) begin
          r_d.phase = r_q.phase + 2'h1;
          if (r_q.phase == 2'h0) r_d.sda_low = 1'b1;
          if (r_q.phase == 2'h1) r_d.scl_low = 1'b1;
          if (r_q.phase == TWS_PH_LAST) seq_end = 1'b1;
        end
      end
      // Repeated start: free both lines, then a start
      TWS_RESTART: begin
        if (qtick) begin
          r_d.phase = r_q.phase + 2'h1;
          if (r_q.phase == 2'h0) r_d.sda_low = 1'b0;
          if (r_q.phase == 2'h1) r_d.scl_low = 1'b0;
          if (r_q.phase == 2'h2) r_d.sda_low = 1'b1;
          if (r_q.phase == TWS_PH_LAST) begin
            r_d.scl_low = 1'b1;
            seq_end = 1'b1;
          end
        end
      end
      // Stop: data low, clock up, then data rises
      TWS_STOP: begin
        if (qtick) begin
          r_d.phase = r_q.phase + 2'h1;
          if (r_q.phase == 2'h0) r_d.sda_low = 1'b1;
          if (r_q.phase == 2'h1) r_d.scl_low = 1'b0;
          if (r_q.phase == 2'h2) r_d.sda_low = 1'b0;
          if (r_q.phase == TWS_PH_LAST) seq_end = 1'b1;
        end
      end
      TWS_XMIT, TWS_RECV, TWS_ACK: begin
        // One bit is four quarters: set data, raise clock, sample, drop clock
        if (qtick) begin
          r_d.phase = r_q.phase + 2'h1;
          if (r_q.phase == 2'h0) begin
            if (r_q.state == TWS_XMIT && r_q.bitn < TWS_BITS_MAX) begin
              r_d.sda_low = !r_q.shreg[7];
            end else if (r_q.state == TWS_ACK) begin
              r_d.sda_low = !r_q.ack_value;
            end else begin
              r_d.sda_low = 1'b0;
            end
          end
          if (r_q.phase == 2'h1) r_d.scl_low = 1'b0;
          // Sample mid high time, clear of both clock edges
          if (r_q.phase == 2'h2) r_d.shreg = {r_q.shreg[6:0], bus_sda};
          if (r_q.phase == TWS_PH_LAST) begin
            r_d.scl_low = 1'b1;
            r_d.bitn = r_q.bitn + 4'h1;
            // Ack is one bit; receive ends after bit eight
            if (r_q.state == TWS_ACK) begin
              seq_end = 1'b1;
            end else if (r_q.state == TWS_RECV && r_q.bitn == TWS_BITS_MAX - 4'h1) begin
              seq_end = 1'b1;
              r_d.rx_hold = r_d.shreg;
              r_d.rx_full = 1'b1;
              ev[TWS_IRQ_RX_DONE] = 1'b1;
            end else if (r_q.state == TWS_XMIT && r_q.bitn == TWS_BITS_MAX) begin
              // Ninth bit was the partner's acknowledge
              seq_end = 1'b1;
              r_d.tx_full = 1'b0;
              ev[TWS_IRQ_TX_DONE] = 1'b1;
            end
          end
        end
      end
      // Unused code falls back to idle
      default: r_d.state = TWS_IDLE;
    endcase

    // End of sequence clears its own request bit
    // Only the request that ran is cleared; queued ones stay
    if (seq_end) begin
      r_d.state = TWS_IDLE;
      // Done event for every sequence, transmit included
      ev[TWS_IRQ_SEQ_DONE] = 1'b1;
      unique case (r_q.state)
        TWS_START: r_d.req[TWS_CTL_START] = 1'b0;
        TWS_RESTART: r_d.req[TWS_CTL_RESTART] = 1'b0;
        TWS_STOP: r_d.req[TWS_CTL_STOP] = 1'b0;
        TWS_RECV: r_d.req[TWS_CTL_RECV] = 1'b0;
        TWS_ACK: r_d.req[TWS_CTL_ACK] = 1'b0;
        default: r_d.req = r_d.req;
      endcase
    end

    // Bus condition tracking and slave address capture
    // The master's own conditions are seen here too
    if (bus_start) begin
      r_d.start_flag = 1'b1;
      r_d.sl_bits = 4'h0;
    end else if (bus_stop) begin
      r_d.start_flag = 1'b0;
      r_d.sl_bits = TWS_BITS_MAX;
      ev[TWS_IRQ_STOP_SEEN] = 1'b1;
    end else if (bus_rise && r_q.enable && r_q.sl_bits < TWS_BITS_MAX) begin
      r_d.sl_shift = {r_q.sl_shift[6:0], bus_sda};
      r_d.sl_bits = r_q.sl_bits + 4'h1;
      if (r_q.sl_bits == TWS_BITS_MAX - 4'h1) begin
        r_d.dir_flag = bus_sda;
      end
    end

    // Register writes; hardware sets below win over software clears
    // Busy refusal keeps a running sequence from being cut
    if (r_q.a_wr) begin
      unique case (r_q.a_off)
        TWS_OFF_CONTROL: begin
          // A new request is taken only while none is pending
          if (r_q.req == '0 && r_q.state == TWS_IDLE) begin
            r_d.req = hwdata_in[TWS_REQ_W-1:0];
          end
          r_d.ack_value = hwdata_in[TWS_CTL_ACKVAL];
        end
        // A full holding register refuses a new byte
        TWS_OFF_TX_HOLD: begin
          if (!r_q.tx_full) begin
            r_d.tx_hold = hwdata_in[7:0];
            r_d.tx_full = 1'b1;
          end
        end
        TWS_OFF_IRQ_STAT: r_d.irq_stat = r_q.irq_stat & ~hwdata_in[TWS_IRQ_W-1:0];
        TWS_OFF_IRQ_MASK: r_d.irq_mask = hwdata_in[TWS_IRQ_W-1:0];
        TWS_OFF_ENABLE: r_d.enable = hwdata_in[0];
        default: r_d.enable = r_d.enable;
      endcase
    end

    // Reading the receive holding register empties it, unless refilled now
    if (r_q.a_rd && r_q.a_off == TWS_OFF_RX_HOLD && !ev[TWS_IRQ_RX_DONE]) begin
      r_d.rx_full = 1'b0;
    end
    // Events land after write-one-to-clear, so a new one is kept
    r_d.irq_stat = r_d.irq_stat | ev;
  end

  // State register
  // Reset clears all: lines free, no request, no event
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  // Zero-wait slave; data is muxed from registers only
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  // Read data only in a read data phase, zero otherwise
  assign hrdata_out = r_q.a_rd ? read_reg(r_q) : 32'h0000_0000;

  // Open-drain lines: drive value is always low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_out = r_q.scl_low;
  assign sda_oe_out = r_q.sda_low;

  // Interrupt while any unmasked event stands
  // Stays high until software clears or masks the event
  assign irq_out = |(r_q.irq_stat & r_q.irq_mask);
endmodule
`default_nettype wire

/* File: sim/tws_bus_slave.sv */
// Behavioural slave device on the two-wire bus, answering the master
`timescale 1ns/1ps
`default_nettype none
module tws_bus_slave (
  input wire logic scl_in, // Clock line level
  input wire logic sda_in, // Data line level
  input wire logic [7:0] send_in, // Byte returned on reads
  output logic sda_oe_out, // Pull data line low
  output logic [7:0] got_out, // Last byte taken
  output logic ack_out // Ninth bit seen
);
  int cnt; // Bits clocked in this byte
  logic addr_ph, rd_mode; // Address byte, slave sends
  logic [7:0] sh; // Shift register
  initial begin
    cnt = 0;
    {addr_ph, rd_mode, sh, got_out, ack_out, sda_oe_out} = '0;
  end
  // Start or repeated start restarts the byte count
  always @(negedge sda_in) if (scl_in) begin
    cnt = 0;
    addr_ph = 1'b1;
    rd_mode = 1'b0;
  end
  // Stop leaves the slave idle
  always @(posedge sda_in) if (scl_in) begin
    addr_ph = 1'b0;
    rd_mode = 1'b0;
  end
  // Sample on the rising clock, MSB first
  always @(posedge scl_in) begin
    if (cnt < 8) begin
      sh = {sh[6:0], sda_in};
    end else begin
      ack_out = sda_in;
      rd_mode = rd_mode && (addr_ph || !sda_in); // NACK ends a read
      addr_ph = 1'b0;
    end
    if (cnt == 7) begin
      got_out = sh;
    end
    if (cnt == 7 && addr_ph) begin
      rd_mode = sda_in;
    end
    cnt = (cnt == 8) ? 0 : cnt + 1;
  end
  // Change data only while the clock is low; released line floats high
  always @(negedge scl_in) begin
    if (rd_mode && !addr_ph && cnt < 8) begin
      sda_oe_out <= !send_in[7-cnt];
    end else begin
      sda_oe_out <= (cnt == 8) && (addr_ph || !rd_mode); // Acknowledge slot
    end
  end
endmodule
`default_nettype wire

/* File: sim/tws_master_chk.sv */
// Checker on the master's ports: line timing, read data and interrupt
`timescale 1ns/1ps
`default_nettype none
module tws_master_chk
  import tws_pkg::*;
(
  input wire logic clk_in, // Clock
  input wire logic rstn_in, // Reset, low
  input wire logic hsel_in, // Select
  input wire logic [31:0] haddr_in, // Address
  input wire logic [1:0] htrans_in, // Transfer
  input wire logic hwrite_in, // Write
  input wire logic [2:0] hsize_in, // Size
  input wire logic [31:0] hwdata_in, // Write data
  input wire logic hready_in, // Bus ready
  input wire logic [31:0] hrdata_out, // Read data
  input wire logic hreadyout_out, // Slave ready
  input wire logic hresp_out, // Response
  input wire logic scl_in, // Clock line
  input wire logic scl_out, // Clock drive
  input wire logic scl_oe_out, // Clock pull
  input wire logic sda_in, // Data line
  input wire logic sda_out, // Data drive
  input wire logic sda_oe_out, // Data pull
  input wire logic irq_out // Interrupt
);
  logic ph_q, wr_q, sda_q, st_q; // Phase, write, line history
  logic [7:0] pa_q; // Data phase offset
  logic [3:0] mask_q, age_q; // Mask copy, settle age
  // Follow bus phases, mask writes and wire conditions
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      {ph_q, wr_q, st_q, pa_q, mask_q, age_q} <= '0;
      sda_q <= 1'b1;
    end else begin
      ph_q <= hsel_in && hready_in && htrans_in == TWS_HTRANS_NONSEQ;
      wr_q <= hwrite_in;
      pa_q <= haddr_in[7:0];
      sda_q <= sda_in;
      if (ph_q && wr_q && pa_q == TWS_OFF_IRQ_MASK) begin // Mask lands
        mask_q <= hwdata_in[3:0];
      end
      if (scl_in && sda_q != sda_in) begin // Start or stop seen
        st_q <= !sda_in;
        age_q <= '0;
      end else if (age_q != 4'hF) begin // Synchroniser needs a few cycles
        age_q <= age_q + 4'h1;
      end
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  a_start_quarter: assert property ($rose(sda_oe_out) && !scl_oe_out |->
    ##[124:127] $rose(scl_oe_out)) else $error("clock not pulled a quarter after start");
  a_stop_idle: assert property ($fell(sda_oe_out) && !scl_oe_out |->
    (!sda_oe_out && !scl_oe_out)[*4]) else $error("lines not left free after stop");
  a_bit_high: assert property ($fell(scl_oe_out) && !sda_oe_out |->
    ##[248:260] $rose(scl_oe_out)) else $error("clock high time wrong");
  a_data_hold: assert property ($fell(scl_oe_out) |-> ##1 $stable(sda_oe_out)[*8])
    else $error("data moved while clock high");
  a_ready_okay: assert property (hreadyout_out && !hresp_out)
    else $error("slave not ready or not okay");
  a_drive_low: assert property (!scl_out && !sda_out)
    else $error("line drive value not low");
  a_rdata_idle: assert property (!(ph_q && !wr_q) |-> hrdata_out == 32'h0)
    else $error("read data outside read phase");
  a_start_seen: assert property (ph_q && !wr_q && pa_q == TWS_OFF_STATUS && age_q > 4'h8 |->
    hrdata_out[TWS_ST_START] == st_q) else $error("start seen bit wrong");
  a_irq_masked: assert property (irq_out |-> mask_q != 4'h0)
    else $error("interrupt while all masked");
  c_start: cover property ($rose(sda_oe_out) && !scl_oe_out);
  c_stop: cover property ($fell(sda_oe_out) && !scl_oe_out);
  c_irq: cover property (irq_out);
endmodule
bind tws_master tws_master_chk chk_u (.clk_in(clk_in), .rstn_in(rstn_in), .hsel_in(hsel_in),
  .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
  .hwdata_in(hwdata_in), .hready_in(hready_in), .hrdata_out(hrdata_out),
  .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .scl_in(scl_in), .scl_out(scl_out),
  .scl_oe_out(scl_oe_out), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
  .irq_out(irq_out));
`default_nettype wire

/* File: sim/twowire_master_seq_status_test.sv */
// Self-checking bench: register sequences against a bus slave model
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, v) begin n_compared++; if ((v) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, v); end end
module twowire_master_seq_status_test;
  import tws_pkg::*;
  logic clk, rstn, hsel, hwrite, hreadyout, hresp, scl_oe, sda_oe, irq, slv_oe, ack;
  logic [1:0] htrans; // Transfer type
  logic [2:0] hsize; // Transfer size
  logic [31:0] haddr, hwdata, hrdata, rd; // Bus values, last read
  logic [7:0] got, send, b; // Slave bytes
  logic [7:0] exp_q[$]; // Expected bytes in order
  int num_errors = 0, n_compared = 0, cyc = 0, i;
  wire scl = !scl_oe; // Pulled up, open drain
  wire sda = !(sda_oe | slv_oe); // Either party pulls low
  tws_master dut_u (.clk_in(clk), .rstn_in(rstn), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hreadyout), .hrdata_out(hrdata), .hreadyout_out(hreadyout), .hresp_out(hresp),
    .scl_in(scl), .scl_out(), .scl_oe_out(scl_oe), .sda_in(sda), .sda_out(),
    .sda_oe_out(sda_oe), .irq_out(irq));
  tws_bus_slave slv_u (.scl_in(scl), .sda_in(sda), .send_in(send), .sda_oe_out(slv_oe),
    .got_out(got), .ack_out(ack));
  // Clock, 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      complete_run;
    end
  end
  task complete_run;
    if (num_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Single word transfer; address held until ready, data until ready again
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= TWS_HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Read until the masked bits clear, bounded
  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    int k;
    k = 0;
    do begin
      ahb(1'b0, a, 32'h0);
      k++;
    end while ((rd & m) != 0 && k < 6000);
    `CHK("poll", 32'h0, rd & m)
  endtask
  // Main sequence
  initial begin
    {rstn, hsel, hwrite, htrans, haddr, hwdata, send} = '0;
    hsize = TWS_HSIZE_WORD;
    void'($urandom(32'h719faf27));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 8; i++) begin // All registers and one unmapped clear
      ahb(1'b0, 8'(i * 4), 32'h0);
      `CHK("reset value", 32'h0, rd)
    end
    ahb(1'b1, 8'h1C, 32'hFFFFFFFF); // Unmapped write dropped
    ahb(1'b0, 8'h1C, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    ahb(1'b1, TWS_OFF_ENABLE, 32'h1); // Address watch on for the direction bit
    ahb(1'b1, TWS_OFF_CONTROL, 32'h1 << TWS_CTL_START);
    poll(TWS_OFF_CONTROL, 32'h3F);
    for (i = 0; i < 2; i++) begin // Write address, then restart and read address
      b = {7'($urandom), i[0]};
      exp_q.push_back(b);
      if (i == 1) begin // Slave's first byte ready before its first drive
        send <= 8'($urandom);
        ahb(1'b1, TWS_OFF_CONTROL, 32'h1 << TWS_CTL_RESTART);
        poll(TWS_OFF_CONTROL, 32'h3F);
      end
      ahb(1'b0, TWS_OFF_STATUS, 32'h0);
      `CHK("start seen", 1'b1, rd[TWS_ST_START])
      ahb(1'b1, TWS_OFF_TX_HOLD, {24'h0, b});
      ahb(1'b0, TWS_OFF_STATUS, 32'h0);
      `CHK("tx full set", 1'b1, rd[TWS_ST_TXFULL])
      poll(TWS_OFF_STATUS, 32'h1 << TWS_ST_TXFULL);
      b = exp_q.pop_front(); // Taken once; the compare uses it twice
      `CHK("byte on wire", b, got)
      ahb(1'b0, TWS_OFF_STATUS, 32'h0);
      `CHK("direction", i[0], rd[TWS_ST_DIR])
    end
    for (i = 0; i < 2; i++) begin // Two received bytes, acked then nacked
      exp_q.push_back(send);
      ahb(1'b1, TWS_OFF_CONTROL, 32'h1 << TWS_CTL_RECV);
      poll(TWS_OFF_CONTROL, 32'h3F);
      ahb(1'b0, TWS_OFF_STATUS, 32'h0);
      `CHK("rx full set", 1'b1, rd[TWS_ST_RXFULL])
      ahb(1'b0, TWS_OFF_RX_HOLD, 32'h0);
      b = exp_q.pop_front();
      `CHK("rx byte", b, rd[7:0])
      ahb(1'b0, TWS_OFF_STATUS, 32'h0);
      `CHK("rx full clear", 1'b0, rd[TWS_ST_RXFULL])
      send <= 8'($urandom);
      ahb(1'b1, TWS_OFF_CONTROL, (32'(i) << TWS_CTL_ACKVAL) | (32'h1 << TWS_CTL_ACK));
      poll(TWS_OFF_CONTROL, 32'h1 << TWS_CTL_ACK);
      `CHK("ack slot", i[0], ack)
    end
    ahb(1'b1, TWS_OFF_CONTROL, (32'h1 << TWS_CTL_RESTART) | (32'h1 << TWS_CTL_STOP));
    ahb(1'b0, TWS_OFF_CONTROL, 32'h0);
    `CHK("queued requests", 32'h6, rd & 32'h1F)
    poll(TWS_OFF_CONTROL, 32'h3F);
    ahb(1'b0, TWS_OFF_STATUS, 32'h0);
    `CHK("start seen clear", 1'b0, rd[TWS_ST_START])
    ahb(1'b0, TWS_OFF_IRQ_STAT, 32'h0); // Every event happened, all masked
    `CHK("irq status", 32'hF, rd)
    `CHK("irq masked", 1'b0, irq)
    ahb(1'b1, TWS_OFF_IRQ_MASK, 32'h1 << TWS_IRQ_RX_DONE);
    ahb(1'b0, TWS_OFF_IRQ_MASK, 32'h0);
    `CHK("irq raised", 1'b1, irq)
    ahb(1'b1, TWS_OFF_IRQ_STAT, 32'h1 << TWS_IRQ_RX_DONE); // Write one clears
    ahb(1'b0, TWS_OFF_IRQ_STAT, 32'h0);
    `CHK("irq cleared", 32'hD, rd)
    `CHK("irq low", 1'b0, irq)
    complete_run;
  end
endmodule
`default_nettype wire
